// >>> hdl/csrp_pkg.sv
// Constants and types shared by the charger serial register port
`default_nettype none
package csrp_pkg;
   // ---------------------------------------------------------------
   // Bus addressing
   // ---------------------------------------------------------------
   localparam logic [6:0] CSRP_SLAVE_ADDR = 7'h6b;
   localparam logic [7:0] CSRP_NUM_REGS = 8'h0a;
   localparam logic [7:0] CSRP_FIRST_CONFIG = 8'h00;
   localparam logic [7:0] CSRP_CHARGE_STATUS = 8'h08;
   localparam logic [7:0] CSRP_FAULT_LATCH = 8'h09;
   localparam logic [3:0] CSRP_BITS_PER_BYTE = 4'h8;
   // ---------------------------------------------------------------
   // Field layout of the fault latch register
   // ---------------------------------------------------------------
   localparam int CSRP_THERM_LSB = 0;
   localparam int CSRP_THERM_W = 3;
   localparam int CSRP_LATCH_LSB = 3;
   localparam int CSRP_LATCH_W = 5;
   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [63:0] CSRP_CONFIG_RST = 64'h0000_0000_0000_0000;
   localparam logic [7:0] CSRP_PTR_RST = 8'h00;
   localparam logic CSRP_LINE_IDLE = 1'b1;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CSRP_CLK_PERIOD_NS = 50;
   localparam int CSRP_FAST_BIT_NS = 2500;
   localparam int CSRP_FAST_BIT_CYCLES = CSRP_FAST_BIT_NS / CSRP_CLK_PERIOD_NS;
   localparam int CSRP_SYNC_STAGES = 3;
   // ---------------------------------------------------------------
   // Bus state machine
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE, ST_DEV, ST_REG, ST_WR, ST_ACK, ST_RD, ST_MACK, ST_IGNORE
   } csrp_state_t;
endpackage
`default_nettype wire

// >>> hdl/csrp_pin_sync.sv
// Three-stage pin synchroniser with an agreement filter
`timescale 1ns/1ps
`default_nettype none
module csrp_pin_sync (
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   input wire logic ce_in,
   input wire logic pin_in,
   output logic level_out
);
   import csrp_pkg::*;
   logic [CSRP_SYNC_STAGES-1:0] stage_q;

   // Chain of flops; first stage feeds only the second
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         stage_q <= {CSRP_SYNC_STAGES{CSRP_LINE_IDLE}};
      end else if (ce_in) begin
         stage_q <= {stage_q[CSRP_SYNC_STAGES-2:0], pin_in};
      end
   end

   // Level follows only when second and third stages agree
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         level_out <= CSRP_LINE_IDLE;
      end else if (ce_in && (stage_q[1] == stage_q[2])) begin
         level_out <= stage_q[2];
      end
   end
endmodule // csrp_pin_sync
`default_nettype wire

// >>> hdl/csrp_port.sv
// Two-wire serial slave port for the charger register set
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Slave acknowledges every accepted byte on the ninth clock pulse.
// - Transmitter releases data during acknowledge; acknowledger holds it low.
// - Data high on the ninth pulse means not-acknowledge.
// - First byte after START holds 7-bit address plus direction bit.
// - Direction zero is write, direction one is read.
// - Undefined register address gets not-acknowledge and machine returns idle.
// - Burst reads and writes work over the first through ninth registers.
// - Fault latch holds a fault until a host read clears it.
// - Read right after a clearing read returns the live fault condition.
// - Fault latch register takes no part in bursts.
// - Respond only to address 6b, at standard and fast speeds.
// - Low three thermistor fault bits never latch, always live.
// - After a fault interrupt, new non-thermistor faults stay silent until read.
module csrp_port (
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   input wire logic ce_in,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_out,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   input wire logic [7:0] charge_status_in,
   input wire logic [7:0] fault_in,
   output logic [63:0] config_out,
   output logic fault_int_out
);
   import csrp_pkg::*;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic is_general(input logic [7:0] p);
      is_general = (p <= CSRP_CHARGE_STATUS);
   endfunction

   function automatic logic [7:0] rd_byte(input logic [7:0] p, input logic [63:0] cfg,
                                          input logic [7:0] stat, input logic [7:0] flt);
      if (p < CSRP_CHARGE_STATUS) begin
         rd_byte = cfg[{p[2:0], 3'b000} +: 8];
      end else if (p == CSRP_CHARGE_STATUS) begin
         rd_byte = stat;
      end else if (p == CSRP_FAULT_LATCH) begin
         rd_byte = flt;
      end else begin
         rd_byte = 8'h00;
      end
   endfunction

   // ---------------------------------------------------------------
   // Pin sampling and bus events
   // ---------------------------------------------------------------
   logic scl_f, sda_f, scl_p_q, sda_p_q;
   logic scl_rise, scl_fall, start_ev, stop_ev;
   csrp_state_t st_q, nxt_q;
   logic [3:0] bit_q;
   logic [7:0] shift_q, ptr_q, ld_ptr, ld_data, fault_view;
   logic rw_q, first_q, mnack_q, sda_oe_q, int_q, pend_q;
   logic [CSRP_LATCH_W-1:0] latch_q;
   logic [CSRP_THERM_W-1:0] therm_p_q;
   logic [63:0] cfg_q;
   logic byte_end, ack_ok, reg_take, wr_take, rd_adv, rd_load, rd_clr, new_f, therm_chg;

   csrp_pin_sync u_scl_sync (
      .clk_sys_in(clk_sys_in),
      .arst_n_in(arst_n_in),
      .ce_in(ce_in),
      .pin_in(scl_in),
      .level_out(scl_f)
   );

   csrp_pin_sync u_sda_sync (
      .clk_sys_in(clk_sys_in),
      .arst_n_in(arst_n_in),
      .ce_in(ce_in),
      .pin_in(sda_in),
      .level_out(sda_f)
   );

   // Previous filtered levels for edge finding
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         scl_p_q <= CSRP_LINE_IDLE;
         sda_p_q <= CSRP_LINE_IDLE;
      end else if (ce_in) begin
         scl_p_q <= scl_f;
         sda_p_q <= sda_f;
      end
   end

   // Clock edges, START and STOP from data moving while clock is high
   assign scl_rise = ce_in & scl_f & ~scl_p_q;
   assign scl_fall = ce_in & ~scl_f & scl_p_q;
   assign start_ev = ce_in & scl_f & scl_p_q & sda_p_q & ~sda_f;
   assign stop_ev = ce_in & scl_f & scl_p_q & ~sda_p_q & sda_f;

   // ---------------------------------------------------------------
   // Byte decisions
   // ---------------------------------------------------------------
   assign byte_end = scl_fall && (bit_q == CSRP_BITS_PER_BYTE) && !start_ev && !stop_ev;

   // Acknowledge decision per receiving state
   always_comb begin
      ack_ok = 1'b0;
      case (st_q)
         ST_DEV: ack_ok = (shift_q[7:1] == CSRP_SLAVE_ADDR);
         ST_REG: ack_ok = (shift_q < CSRP_NUM_REGS);
         ST_WR: ack_ok = is_general(ptr_q) || ((ptr_q == CSRP_FAULT_LATCH) && first_q);
         default: ack_ok = 1'b0;
      endcase
   end

   assign reg_take = byte_end && (st_q == ST_REG) && ack_ok;
   assign wr_take = byte_end && (st_q == ST_WR) && ack_ok;
   assign rd_adv = scl_fall && (st_q == ST_MACK) && !mnack_q && (ptr_q < CSRP_CHARGE_STATUS) && !start_ev
                   && !stop_ev;
   assign rd_load = (scl_fall && (st_q == ST_ACK) && (nxt_q == ST_RD) && !start_ev && !stop_ev) || rd_adv;
   assign ld_ptr = rd_adv ? 8'(ptr_q + 8'h01) : ptr_q;
   assign fault_view = {latch_q | fault_in[CSRP_LATCH_LSB +: CSRP_LATCH_W], fault_in[CSRP_THERM_LSB +: CSRP_THERM_W]};
   assign ld_data = rd_byte(ld_ptr, cfg_q, charge_status_in, fault_view);
   assign rd_clr = rd_load && (ld_ptr == CSRP_FAULT_LATCH);

   // ---------------------------------------------------------------
   // Bus state machine
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_q <= ST_IDLE;
         nxt_q <= ST_IDLE;
         bit_q <= 4'h0;
         shift_q <= 8'h00;
         rw_q <= 1'b0;
         mnack_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end else if (ce_in) begin
         if (start_ev) begin
            st_q <= ST_DEV;
            bit_q <= 4'h0;
            sda_oe_q <= 1'b0;
         end else if (stop_ev) begin
            st_q <= ST_IDLE;
            sda_oe_q <= 1'b0;
         end else begin
            case (st_q)
               ST_DEV, ST_REG, ST_WR: begin
                  if (scl_rise && (bit_q != CSRP_BITS_PER_BYTE)) begin
                     shift_q <= {shift_q[6:0], sda_f};
                     bit_q <= 4'(bit_q + 4'h1);
                  end else if (byte_end) begin
                     if (ack_ok) begin
                        st_q <= ST_ACK;
                        sda_oe_q <= 1'b1;
                        if (st_q == ST_DEV) begin
                           rw_q <= shift_q[0];
                           nxt_q <= shift_q[0] ? ST_RD : ST_REG;
                        end else begin
                           nxt_q <= ST_WR;
                        end
                     end else begin
                        st_q <= (st_q == ST_REG) ? ST_IDLE : ST_IGNORE;
                     end
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     bit_q <= 4'h0;
                     st_q <= nxt_q;
                     shift_q <= rd_load ? ld_data : shift_q;
                     sda_oe_q <= rd_load ? ~ld_data[7] : 1'b0;
                  end
               end
               ST_RD: begin
                  if (scl_fall) begin
                     if (bit_q == 4'h7) begin
                        sda_oe_q <= 1'b0;
                        st_q <= ST_MACK;
                     end else begin
                        shift_q <= {shift_q[6:0], 1'b0};
                        sda_oe_q <= ~shift_q[6];
                        bit_q <= 4'(bit_q + 4'h1);
                     end
                  end
               end
               ST_MACK: begin
                  if (scl_rise) begin
                     mnack_q <= sda_f;
                  end else if (scl_fall) begin
                     bit_q <= 4'h0;
                     st_q <= rd_adv ? ST_RD : ST_IGNORE;
                     shift_q <= rd_adv ? ld_data : shift_q;
                     sda_oe_q <= rd_adv ? ~ld_data[7] : 1'b0;
                  end
               end
               default: ;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Register pointer and config storage
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ptr_q <= CSRP_PTR_RST;
         first_q <= 1'b0;
      end else if (ce_in) begin
         if (reg_take) begin
            ptr_q <= shift_q;
            first_q <= 1'b1;
         end else if (wr_take || rd_adv) begin
            ptr_q <= 8'(ptr_q + 8'h01);
            first_q <= 1'b0;
         end
      end
   end

   // Writable config bytes; status and fault bytes are read-only
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cfg_q <= CSRP_CONFIG_RST;
      end else if (ce_in && wr_take && (ptr_q < CSRP_CHARGE_STATUS)) begin
         cfg_q[{ptr_q[2:0], 3'b000} +: 8] <= shift_q;
      end
   end

   // ---------------------------------------------------------------
   // Fault latch and fault interrupt
   // ---------------------------------------------------------------
   assign new_f = |(fault_in[CSRP_LATCH_LSB +: CSRP_LATCH_W] & ~latch_q);
   assign therm_chg = (fault_in[CSRP_THERM_LSB +: CSRP_THERM_W] != therm_p_q);

   // Live faults always enter, so a fault in the clearing cycle survives
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         latch_q <= '0;
      end else if (ce_in) begin
         if (rd_clr) begin
            latch_q <= fault_in[CSRP_LATCH_LSB +: CSRP_LATCH_W];
         end else begin
            latch_q <= latch_q | fault_in[CSRP_LATCH_LSB +: CSRP_LATCH_W];
         end
      end
   end

   // One-cycle interrupt pulse; pending blocks repeats until fault read
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         int_q <= 1'b0;
         pend_q <= 1'b0;
         therm_p_q <= '0;
      end else if (ce_in) begin
         therm_p_q <= fault_in[CSRP_THERM_LSB +: CSRP_THERM_W];
         int_q <= (new_f && (!pend_q || rd_clr)) || therm_chg;
         pend_q <= new_f ? 1'b1 : (rd_clr ? 1'b0 : pend_q);
      end else begin
         int_q <= 1'b0;
      end
   end

   // Clock and data never driven high; clock line never driven at all
   assign scl_out = 1'b0;
   assign scl_oe_out = 1'b0;
   assign sda_out = 1'b0;
   assign sda_oe_out = sda_oe_q;
   assign config_out = cfg_q;
   assign fault_int_out = int_q;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!arst_n_in);

   property p_ack_hold;
      (st_q == ST_ACK) && scl_rise |=> sda_oe_q [*2];
   endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("ack released during ninth pulse");

   property p_addr_miss;
      byte_end && (st_q == ST_DEV) && (shift_q[7:1] != CSRP_SLAVE_ADDR) |=> (st_q == ST_IGNORE) && !sda_oe_q;
   endproperty
   a_addr_miss: assert property (p_addr_miss) else $error("foreign address answered");

   property p_dir;
      byte_end && (st_q == ST_DEV) && ack_ok |=> (st_q == ST_ACK) && sda_oe_q
         && (nxt_q == ($past(shift_q[0]) ? ST_RD : ST_REG));
   endproperty
   a_dir: assert property (p_dir) else $error("direction bit misdecoded");

   property p_bad_reg;
      byte_end && (st_q == ST_REG) && (shift_q >= CSRP_NUM_REGS) |=> (st_q == ST_IDLE) && !sda_oe_q;
   endproperty
   a_bad_reg: assert property (p_bad_reg) else $error("undefined register acknowledged");

   property p_ptr_step;
      wr_take |=> (ptr_q == 8'($past(ptr_q) + 8'h01)) && (st_q == ST_ACK);
   endproperty
   a_ptr_step: assert property (p_ptr_step) else $error("pointer did not step");

   property p_burst_fault;
      byte_end && (st_q == ST_WR) && !first_q && (ptr_q == CSRP_FAULT_LATCH) |=> (st_q == ST_IGNORE);
   endproperty
   a_burst_fault: assert property (p_burst_fault) else $error("fault register taken in burst");

   property p_latch_hold;
      !rd_clr |=> ((latch_q & $past(latch_q)) == $past(latch_q));
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("fault latch lost a bit");

   property p_clear_live;
      rd_clr && ce_in |=> (latch_q == $past(fault_in[CSRP_LATCH_LSB +: CSRP_LATCH_W]));
   endproperty
   a_clear_live: assert property (p_clear_live) else $error("clearing read kept old fault");

   property p_therm_live;
      rd_load && ce_in && (ld_ptr == CSRP_FAULT_LATCH) |=> (shift_q[2:0] == $past(fault_in[2:0]));
   endproperty
   a_therm_live: assert property (p_therm_live) else $error("thermistor bits not live");

   property p_int_quiet;
      ce_in && pend_q && !rd_clr && !therm_chg |=> !int_q;
   endproperty
   a_int_quiet: assert property (p_int_quiet) else $error("interrupt repeated before read");
endmodule // csrp_port
`default_nettype wire

// >>> dv/csrp_host_model.sv
// Bus master model that drives the two-wire link as a host controller
`timescale 1ns/1ps
`default_nettype none
module csrp_host_model (
   input wire logic clk_sys_in,
   input wire logic sda_in,
   output logic scl_oe_out,
   output logic sda_oe_out
);
   // Quarter of a bit time in system clocks; the bench changes it for the slow speed
   int quarter_clks = 13;
   // Both lines released at time zero, so the pull-ups hold them high
   initial begin
      scl_oe_out = 1'b0;
      sda_oe_out = 1'b0;
   end
   // Wait a quarter bit
   task automatic qwait();
      repeat (quarter_clks) @(posedge clk_sys_in);
   endtask
   // Start or repeated start: data falls while the clock is high
   task automatic start_cond();
      qwait();
      sda_oe_out <= 1'b0;
      qwait();
      scl_oe_out <= 1'b0;
      qwait();
      sda_oe_out <= 1'b1;
      qwait();
      scl_oe_out <= 1'b1;
   endtask
   // Stop: data rises while the clock is high, leaving the bus free
   task automatic stop_cond();
      qwait();
      sda_oe_out <= 1'b1;
      qwait();
      scl_oe_out <= 1'b0;
      qwait();
      sda_oe_out <= 1'b0;
      qwait();
   endtask
   // One clock pulse; data set only while the clock is low, sampled mid-high
   task automatic bit_xfer(input logic b, output logic r);
      qwait();
      sda_oe_out <= ~b;
      qwait();
      scl_oe_out <= 1'b0;
      qwait();
      r = sda_in;
      qwait();
      scl_oe_out <= 1'b1;
   endtask
   // Send one byte MSB first, release data on the ninth pulse and read the answer
   task automatic tx_byte(input logic [7:0] d, output logic acked);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(d[i], r);
      end
      bit_xfer(1'b1, r);
      acked = ~r;
   endtask
   // Receive one byte with data released, then acknowledge or refuse it
   task automatic rx_byte(output logic [7:0] d, input logic mack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(1'b1, d[i]);
      end
      bit_xfer(~mack, r);
   endtask
endmodule // csrp_host_model
`default_nettype wire

// >>> dv/charger_serial_register_port_test.sv
// Self-checking bench for the charger serial register port
`timescale 1ns/1ps
`default_nettype none
module charger_serial_register_port_test;
   import csrp_pkg::*;
   // ---------------------------------------------------------------
   // Stimulus, wires and instances
   // ---------------------------------------------------------------
   logic clk_sys_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic ce_in = 1'b1;
   logic [7:0] charge_status_in = 8'ha5;
   logic [7:0] fault_in = 8'h00;
   logic dut_scl, dut_scl_oe, dut_sda, dut_sda_oe, host_scl_oe, host_sda_oe, fault_int;
   logic scl_line, sda_line;
   logic [63:0] config_q;
   logic [63:0] exp_cfg;
   int err_count = 0;
   int checks_done = 0;
   localparam logic [7:0] ADDR_W = {CSRP_SLAVE_ADDR, 1'b0};
   localparam logic [7:0] ADDR_R = {CSRP_SLAVE_ADDR, 1'b1};
   // Open-drain lines with pull-ups: low whenever any party enables its driver
   assign scl_line = ~(host_scl_oe | dut_scl_oe);
   assign sda_line = ~(host_sda_oe | dut_sda_oe);
   // System clock, 50 ns period
   always #25 clk_sys_in = ~clk_sys_in;
   csrp_port dut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .ce_in(ce_in), .scl_in(scl_line),
      .scl_out(dut_scl), .scl_oe_out(dut_scl_oe), .sda_in(sda_line), .sda_out(dut_sda),
      .sda_oe_out(dut_sda_oe), .charge_status_in(charge_status_in), .fault_in(fault_in),
      .config_out(config_q), .fault_int_out(fault_int));
   csrp_host_model host (.clk_sys_in(clk_sys_in), .sda_in(sda_line), .scl_oe_out(host_scl_oe),
      .sda_oe_out(host_sda_oe));
   // ---------------------------------------------------------------
   // Comparison and reporting
   // ---------------------------------------------------------------
   task automatic fail(input string msg);
      err_count++;
      $display("[FAIL] %0t %s", $time, msg);
   endtask
   task automatic chk1(input logic got, input logic exp, input string msg);
      checks_done++;
      if (got !== exp) fail(msg);
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
      checks_done++;
      if (got !== exp) fail($sformatf("%s got %h exp %h", msg, got, exp));
   endtask
   task automatic chk64(input logic [63:0] got, input logic [63:0] exp, input string msg);
      checks_done++;
      if (got !== exp) fail($sformatf("%s got %h exp %h", msg, got, exp));
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Bus helpers
   // ---------------------------------------------------------------
   task automatic send(input logic [7:0] b, input logic exp_ack, input string msg);
      logic a;
      host.tx_byte(b, a);
      chk1(a, exp_ack, msg);
   endtask
   task automatic set_ptr(input logic [7:0] r);
      host.start_cond();
      send(ADDR_W, 1'b1, "write address not acked");
      send(r, 1'b1, "register byte not acked");
   endtask
   task automatic read_one(input logic [7:0] r, input logic [7:0] exp, input string msg);
      logic [7:0] d;
      set_ptr(r);
      host.start_cond();
      send(ADDR_R, 1'b1, "read address not acked");
      host.rx_byte(d, 1'b0);
      host.stop_cond();
      chk8(d, exp, msg);
   endtask
   task automatic set_fault(input logic [7:0] v, input logic exp_int, input string msg);
      logic seen;
      seen = 1'b0;
      @(posedge clk_sys_in);
      fault_in <= v;
      repeat (20) begin
         @(negedge clk_sys_in);
         if (fault_int === 1'b1) seen = 1'b1;
      end
      chk1(seen, exp_int, msg);
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      chk64(config_q, CSRP_CONFIG_RST, "config not cleared by reset");
      chk1(dut_sda_oe, 1'b0, "data driven after reset");
      chk1(dut_scl_oe, 1'b0, "clock driven by port");
      chk1(dut_sda, 1'b0, "data pin would drive high");
      chk1(dut_scl, 1'b0, "clock pin would drive high");
   endtask
   task automatic t_addr_slow();
      host.quarter_clks = 50;
      host.start_cond();
      send({7'h6a, 1'b0}, 1'b0, "foreign address acked");
      host.stop_cond();
      host.start_cond();
      send({7'h2b, 1'b0}, 1'b0, "foreign address acked");
      host.stop_cond();
      set_ptr(CSRP_FIRST_CONFIG);
      send(8'h3c, 1'b1, "slow data not acked");
      host.stop_cond();
      exp_cfg[7:0] = 8'h3c;
      chk64(config_q, exp_cfg, "slow write lost");
      host.quarter_clks = 13;
   endtask
   task automatic t_burst_wr();
      set_ptr(CSRP_FIRST_CONFIG);
      for (int i = 0; i < 8; i++) begin
         send(8'((i + 1) * 17), 1'b1, "burst byte not acked");
         exp_cfg[8 * i +: 8] = 8'((i + 1) * 17);
      end
      send(8'h99, 1'b1, "status register byte not acked");
      send(8'h77, 1'b0, "fault register took burst byte");
      host.stop_cond();
      chk64(config_q, exp_cfg, "burst write content");
   endtask
   task automatic t_burst_rd();
      logic [7:0] d;
      logic [7:0] e;
      set_ptr(CSRP_FIRST_CONFIG);
      host.start_cond();
      send(ADDR_R, 1'b1, "read address not acked");
      for (int i = 0; i < 10; i++) begin
         host.rx_byte(d, i < 9);
         e = (i < 8) ? 8'((i + 1) * 17) : ((i == 8) ? charge_status_in : 8'hff);
         chk8(d, e, "burst read byte");
      end
      host.stop_cond();
   endtask
   task automatic t_bad_reg();
      host.start_cond();
      send(ADDR_W, 1'b1, "address not acked");
      send(CSRP_NUM_REGS, 1'b0, "undefined register acked");
      send(8'h00, 1'b0, "byte acked after undefined register");
      host.stop_cond();
      chk64(config_q, exp_cfg, "config changed by refused write");
      set_ptr(8'h03);
      send(8'h5a, 1'b1, "single write not acked");
      host.stop_cond();
      exp_cfg[31:24] = 8'h5a;
      chk64(config_q, exp_cfg, "single write content");
      read_one(8'h03, 8'h5a, "single read");
   endtask
   task automatic t_fault();
      set_fault(8'h28, 1'b1, "no interrupt on new fault");
      set_fault(8'h68, 1'b0, "second interrupt before read");
      set_fault(8'h69, 1'b1, "no interrupt on thermistor change");
      set_fault(8'h00, 1'b1, "no interrupt on thermistor clear");
      read_one(CSRP_FAULT_LATCH, 8'h68, "first fault read");
      read_one(CSRP_FAULT_LATCH, 8'h00, "second fault read");
      set_fault(8'h80, 1'b1, "no interrupt after clearing read");
      read_one(CSRP_FAULT_LATCH, 8'h80, "live fault read");
   endtask
   // Clock enable low freezes everything but the interrupt, which is held low; the held-back fault shows once it runs again
   task automatic t_freeze();
      @(posedge clk_sys_in);
      ce_in <= 1'b0;
      set_fault(8'h10, 1'b0, "interrupt while frozen");
      chk64(config_q, exp_cfg, "config moved while frozen");
      @(posedge clk_sys_in);
      ce_in <= 1'b1;
      set_fault(8'h10, 1'b1, "no interrupt after resume");
      read_one(CSRP_FAULT_LATCH, 8'h90, "fault after resume");
   endtask
   // Watchdog against a hung bus
   initial begin
      repeat (100000) @(posedge clk_sys_in);
      fail("timeout");
      stop_test();
   end
   // Main sequence
   initial begin
      exp_cfg = CSRP_CONFIG_RST;
      repeat (3) @(posedge clk_sys_in);
      arst_n_in <= 1'b1;
      repeat (6) @(posedge clk_sys_in);
      t_reset();
      t_addr_slow();
      t_burst_wr();
      t_burst_rd();
      t_bad_reg();
      t_fault();
      t_freeze();
      stop_test();
   end
endmodule // charger_serial_register_port_test
`default_nettype wire
